// [dv/cmir_dma_model.sv]
// Behavioural DMA channel answering a request with a one-cycle done pulse
`timescale 1ns/100ps
module cmir_dma_model #(
  parameter int DLY = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dma_req,
  output logic dma_done
);
  int cnt;
  // Wait DLY cycles, pulse once, then count DLY cycles again while the request stays high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      dma_done <= 1'b0;
    end else begin
      dma_done <= dma_req && !dma_done && cnt >= DLY - 1;
      cnt <= (dma_req && !dma_done) ? cnt + 1 : 0;
    end
  end
endmodule

// [dv/cmir_props.sv]
// Port-level assertions and covers for the match interrupt router
`timescale 1ns/100ps
module cmir_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ch0_match_irq,
  input wire logic ch1_match_irq,
  input wire logic ch0_dma_req,
  input wire logic ch1_dma_req,
  input wire logic ch0_dma_done,
  input wire logic ch1_dma_done,
  input wire logic xfer_req,
  input wire logic xfer_chan
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only a write or a transfer may drop a raised request
  chk_irq0_hold: assert property (
    ch0_match_irq && !psel && !ch0_dma_done |=> ch0_match_irq) else $error("irq0 dropped");
  chk_irq1_hold: assert property (
    ch1_match_irq && !psel && !ch1_dma_done |=> ch1_match_irq) else $error("irq1 dropped");
  chk_route0_excl: assert property (
    !(ch0_match_irq && ch0_dma_req)) else $error("irq0 with dma0");
  chk_route1_excl: assert property (
    !(ch1_match_irq && ch1_dma_req)) else $error("irq1 with dma1");
  chk_dma0_clear: assert property (
    ch0_dma_done |=> !ch0_dma_req) else $error("dma0 not cleared");
  chk_dma1_clear: assert property (
    ch1_dma_done |=> !ch1_dma_req) else $error("dma1 not cleared");
  chk_ready_high: assert property (
    psel && penable |-> pready) else $error("pready low");
  chk_err_phase: assert property (
    pslverr |-> psel && penable) else $error("pslverr outside access");
  cover property (ch0_match_irq);
  cover property (ch1_dma_req);
  cover property (xfer_req && xfer_chan);
endmodule
bind cmir_top cmir_props u_cmir_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .ch0_match_irq, .ch1_match_irq, .ch0_dma_req, .ch1_dma_req, .ch0_dma_done,
  .ch1_dma_done, .xfer_req, .xfer_chan);

// [dv/compare_match_irq_routing_test.sv]
// Register-level tests of the match interrupt router
`timescale 1ns/100ps
`include "cmir_consts.svh"
module compare_match_irq_routing_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, i0, i1, d0, d1, dn0, dn1, xr, xc, irq;
  logic [15:0] c0 = '0, c1 = '0;
  logic ce = 1'b1;
  int err_count = 0, num_checks = 0;
  cmir_top u_cmir_top (.pclk, .presetn, .clk_en(ce), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ch0_count(c0), .ch1_count(c1),
    .ch0_dma_done(dn0), .ch1_dma_done(dn1), .ch0_match_irq(i0), .ch1_match_irq(i1),
    .ch0_dma_req(d0), .ch1_dma_req(d1), .xfer_req(xr), .xfer_chan(xc), .irq);
  // Prompt DMA on channel 0, slow one on channel 1
  cmir_dma_model #(.DLY(1)) u_cmir_dma_model (.pclk, .presetn, .dma_req(d0), .dma_done(dn0));
  cmir_dma_model #(.DLY(6)) u_cmir_dma_model_1 (.pclk, .presetn, .dma_req(d1), .dma_done(dn1));
  initial forever #25 pclk = ~pclk;
  // Watchdog: the tests need about 110 cycles
  initial begin
    #100000;
    err_count++;
    print_verdict;
  end
  task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    ap(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // One-cycle match on the chosen channels; flag is visible after
  task hit(input logic [1:0] m);
    @(posedge pclk);
    c0 <= m[0] ? 16'h0010 : 16'h0000;
    c1 <= m[1] ? 16'h0020 : 16'h0000;
    @(posedge pclk);
    c0 <= 16'h0000;
    c1 <= 16'h0000;
    @(posedge pclk);
    #1;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`CMIR_OFS_CTRL, 32'h0);
    rchk(`CMIR_OFS_CMP0, 32'hffff);
    ap(1'b1, 12'h018, 32'h1);
    chk(err, 1'b1);
    $display("test reset done");
    ap(1'b1, `CMIR_OFS_CMP0, 32'h10);
    ap(1'b1, `CMIR_OFS_CMP1, 32'h20);
    chk(err, 1'b0);
    hit(2'h3);
    chk({i0, i1}, 2'h0);
    rchk(`CMIR_OFS_STAT, 32'h3);
    ap(1'b1, `CMIR_OFS_CTRL, 32'h3);
    repeat (4) @(posedge pclk);
    chk({i0, i1}, 2'h3);
    // Each channel has its own line, unranked; this handler serves channel 0 first
    ap(1'b1, `CMIR_OFS_STAT, 32'h1);
    chk({i0, i1}, 2'h1);
    ap(1'b1, `CMIR_OFS_STAT, 32'h2);
    $display("test cpu route done");
    chk(irq, 1'b0);
    ap(1'b1, `CMIR_OFS_EVMSK, 32'h1);
    chk(irq, 1'b1);
    rchk(`CMIR_OFS_EVST, 32'h3);
    chk(irq, 1'b0);
    hit(2'h2);
    chk({irq, i1}, 2'h1);
    hit(2'h1);
    chk({irq, i0}, 2'h3);
    rchk(`CMIR_OFS_EVST, 32'h3);
    ap(1'b1, `CMIR_OFS_STAT, 32'h3);
    $display("test status irq done");
    ap(1'b1, `CMIR_OFS_CTRL, 32'hf);
    hit(2'h3);
    chk({d0, d1, i0, i1}, 4'hc);
    repeat (10) @(posedge pclk);
    rchk(`CMIR_OFS_STAT, 32'h0);
    $display("test dma route done");
    ap(1'b1, `CMIR_OFS_CTRL, 32'h33);
    hit(2'h3);
    chk({xr, xc, i0}, 3'h4);
    ap(1'b1, `CMIR_OFS_STAT, 32'h1);
    chk({xr, xc}, 2'h3);
    ap(1'b1, `CMIR_OFS_STAT, 32'h2);
    chk(xr, 1'b0);
    $display("test transfer route done");
    // Clock enable low freezes the flags: a match then is lost
    @(posedge pclk);
    ce <= 1'b0;
    hit(2'h1);
    @(posedge pclk);
    ce <= 1'b1;
    rchk(`CMIR_OFS_STAT, 32'h0);
    hit(2'h1);
    rchk(`CMIR_OFS_STAT, 32'h1);
    ap(1'b1, `CMIR_OFS_STAT, 32'h1);
    $display("test clock enable done");
    print_verdict;
  end
endmodule

// [shared/cmir_consts.svh]
// Register offsets, field positions and reset values for the match interrupt router
`ifndef CMIR_CONSTS_SVH
`define CMIR_CONSTS_SVH
`define CMIR_OFS_CTRL 12'h000
`define CMIR_OFS_STAT 12'h004
`define CMIR_OFS_CMP0 12'h008
`define CMIR_OFS_CMP1 12'h00c
`define CMIR_OFS_EVST 12'h010
`define CMIR_OFS_EVMSK 12'h014
`define CMIR_CTRL_IE0 0
`define CMIR_CTRL_IE1 1
`define CMIR_CTRL_DMA0 2
`define CMIR_CTRL_DMA1 3
`define CMIR_CTRL_XFER0 4
`define CMIR_CTRL_XFER1 5
`define CMIR_CTRL_RST 6'h00
`define CMIR_CMP_RST 16'hffff
`define CMIR_EVMSK_RST 2'h0
`define CMIR_CNT_W 16
`endif

// [shared/cmir_pkg.sv]
// Types shared by the match interrupt router files
package cmir_pkg;
  // Destination chosen for a channel's request
  typedef enum logic [2:0] {
    CMIR_RT_CPU = 3'h1,
    CMIR_RT_DMA = 3'h2,
    CMIR_RT_XFER = 3'h4
  } cmir_route_e;
endpackage

// [verilog/cmir_chan.sv]
// One compare-match channel: match flag set, clear and request routing
`timescale 1ns/100ps
`include "cmir_consts.svh"
module cmir_chan #(
  parameter int CNT_W = `CMIR_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [CNT_W-1:0] count,
  input wire logic [CNT_W-1:0] compare,
  input wire logic irq_enable,
  input wire logic use_dma,
  input wire logic use_xfer,
  input wire logic sw_clear,
  input wire logic dma_done,
  output logic match_flag,
  output logic match_event,
  output logic cpu_req,
  output logic dma_req,
  output logic xfer_req
);
  logic hit;
  logic req;
  logic next_flag;
  cmir_pkg::cmir_route_e route;

  // ---------------------------------------------
  // Flag update
  // ---------------------------------------------
  // match sets flag
  assign hit = (count == compare);
  assign match_event = hit;
  // transfer clears flag; set wins over any clear
  assign next_flag = hit ? 1'b1 : ((sw_clear | dma_done) ? 1'b0 : match_flag);

  // Flag register, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag <= 1'b0;
    end else if (clk_en) begin
      match_flag <= next_flag;
    end
  end

  // ---------------------------------------------
  // Request routing
  // ---------------------------------------------
  // flag and enable raise request
  assign req = match_flag & irq_enable;
  // DMA takes precedence over the transfer controller when both are set
  assign route = use_dma ? cmir_pkg::CMIR_RT_DMA :
                 (use_xfer ? cmir_pkg::CMIR_RT_XFER : cmir_pkg::CMIR_RT_CPU);
  assign dma_req = req & (route == cmir_pkg::CMIR_RT_DMA);
  assign xfer_req = req & (route == cmir_pkg::CMIR_RT_XFER);
  // default route is CPU; held flag keeps request up
  assign cpu_req = req & (route == cmir_pkg::CMIR_RT_CPU);
endmodule

// [verilog/cmir_top.sv]
// Two-channel compare-match interrupt and transfer-request router with APB registers
//
// Overview of operation
// - Channel request is raised while its match flag and interrupt enable are both 1.
// - With DMA routing chosen, the request goes to DMA, never to the CPU.
// - With neither DMA nor transfer routing, the request is delivered to the CPU as an interrupt.
// - A DMA transfer for the channel clears its match flag automatically.
// - Transfer controller requests use fixed priority, channel 0 above channel 1.
// - Each channel has its own interrupt line; either may start DMA or transfers.
`timescale 1ns/100ps
`include "cmir_consts.svh"

// ---------------------------------------------
// Register map (byte addresses, one 32-bit word each)
// ---------------------------------------------
// CTRL  0x000: bits 1:0 irq enable, 3:2 DMA route, 5:4 transfer route
// STAT  0x004: bits 1:0 match flags, write 1 to clear
// CMP0  0x008: channel 0 compare value
// CMP1  0x00c: channel 1 compare value
// EVST  0x010: sticky match events, cleared by a read
// EVMSK 0x014: a 1 lets the event onto irq
// Unused bits read 0; unmapped addresses answer with pslverr
module cmir_top #(
  parameter int CNT_W = `CMIR_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CNT_W-1:0] ch0_count,
  input wire logic [CNT_W-1:0] ch1_count,
  input wire logic ch0_dma_done,
  input wire logic ch1_dma_done,
  output logic ch0_match_irq,
  output logic ch1_match_irq,
  output logic ch0_dma_req,
  output logic ch1_dma_req,
  output logic xfer_req,
  output logic xfer_chan,
  output logic irq
);
  logic [5:0] ctrl;
  logic [CNT_W-1:0] cmp [2];
  logic [1:0] evst;
  logic [1:0] evmsk;
  logic [1:0] flag;
  logic [1:0] event_hit;
  logic [1:0] clr;
  logic [1:0] cpu_req;
  logic [1:0] dma_req;
  logic [1:0] xreq;
  logic [1:0] done;
  logic [CNT_W-1:0] cnt [2];
  logic [31:0] next_prdata;
  logic access;
  logic wr;
  logic rd;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_cmp0;
  logic sel_cmp1;
  logic sel_evst;
  logic sel_evmsk;
  logic mapped;
  logic [1:0] evst_clr;

  // ---------------------------------------------
  // APB decode
  // ---------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign access = psel & penable & clk_en;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  // Offset compare shared by every register select
  function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

  assign sel_ctrl = is_reg(paddr, `CMIR_OFS_CTRL);
  assign sel_stat = is_reg(paddr, `CMIR_OFS_STAT);
  assign sel_cmp0 = is_reg(paddr, `CMIR_OFS_CMP0);
  assign sel_cmp1 = is_reg(paddr, `CMIR_OFS_CMP1);
  assign sel_evst = is_reg(paddr, `CMIR_OFS_EVST);
  assign sel_evmsk = is_reg(paddr, `CMIR_OFS_EVMSK);
  assign mapped = sel_ctrl | sel_stat | sel_cmp0 | sel_cmp1 | sel_evst | sel_evmsk;
  // Unmapped addresses answer with an error and read zero
  assign pslverr = psel & penable & ~mapped;

  // Read mux: if / else-if chain on the decoded address
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_ctrl) begin
      next_prdata[5:0] = ctrl;
    end else if (sel_stat) begin
      next_prdata[1:0] = flag;
    end else if (sel_cmp0) begin
      next_prdata[CNT_W-1:0] = cmp[0];
    end else if (sel_cmp1) begin
      next_prdata[CNT_W-1:0] = cmp[1];
    end else if (sel_evst) begin
      next_prdata[1:0] = evst;
    end else if (sel_evmsk) begin
      next_prdata[1:0] = evmsk;
    end
  end

  // Read data registered in the setup cycle so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------
  // Configuration registers
  // ---------------------------------------------
  // Control: enables and route choice, written as a whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CMIR_CTRL_RST;
    end else if (wr && sel_ctrl) begin
      ctrl <= pwdata[5:0];
    end
  end

  // Compare values; a write lands only on the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp[0] <= CNT_W'(`CMIR_CMP_RST);
      cmp[1] <= CNT_W'(`CMIR_CMP_RST);
    end else if (wr) begin
      if (sel_cmp0) begin
        cmp[0] <= pwdata[CNT_W-1:0];
      end
      if (sel_cmp1) begin
        cmp[1] <= pwdata[CNT_W-1:0];
      end
    end
  end

  // Event mask for the summary interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evmsk <= `CMIR_EVMSK_RST;
    end else if (wr && sel_evmsk) begin
      evmsk <= pwdata[1:0];
    end
  end

  // Software clears a match flag by writing 1 to its status bit
  assign clr = {2{wr & sel_stat}} & pwdata[1:0];
  assign done = {ch1_dma_done, ch0_dma_done};
  assign cnt[0] = ch0_count;
  assign cnt[1] = ch1_count;

  // ---------------------------------------------
  // Channels
  // ---------------------------------------------
  // independent source per channel
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      cmir_chan #(.CNT_W(CNT_W)) u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .count(cnt[g]),
        .compare(cmp[g]),
        .irq_enable(ctrl[`CMIR_CTRL_IE0 + g]),
        .use_dma(ctrl[`CMIR_CTRL_DMA0 + g]),
        .use_xfer(ctrl[`CMIR_CTRL_XFER0 + g]),
        .sw_clear(clr[g]),
        .dma_done(done[g]),
        .match_flag(flag[g]),
        .match_event(event_hit[g]),
        .cpu_req(cpu_req[g]),
        .dma_req(dma_req[g]),
        .xfer_req(xreq[g])
      );
    end
  endgenerate

  // ---------------------------------------------
  // Request outputs
  // ---------------------------------------------
  // one irq and one DMA line per channel; transfer requests share xfer_req
  assign ch0_match_irq = cpu_req[0];
  assign ch1_match_irq = cpu_req[1];
  assign ch0_dma_req = dma_req[0];
  assign ch1_dma_req = dma_req[1];
  assign xfer_req = |xreq;
  assign xfer_chan = ~xreq[0] & xreq[1];

  // ---------------------------------------------
  // Event status and summary interrupt
  // ---------------------------------------------
  // A read clears only the bits it returned, so an event that lands
  // between the setup and the access cycle is not lost
  assign evst_clr = (rd && sel_evst) ? prdata[1:0] : 2'h0;

  // Sticky match events; a read clears them, but a new event in that cycle stays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evst <= 2'h0;
    end else if (clk_en) begin
      evst <= event_hit | (evst & ~evst_clr);
    end
  end

  // Level output; mask bit 1 lets the event through
  assign irq = |(evst & evmsk);
endmodule
